// ===== hdl/cft_defines.svh
// Register map, field positions, reset values and limits of the closure-fault trip block
`ifndef CFT_DEFINES_SVH
`define CFT_DEFINES_SVH
`define CFT_AW 12
`define CFT_ADDR_CTRL 12'h000
`define CFT_ADDR_THR 12'h004
`define CFT_ADDR_STAT 12'h008
`define CFT_CTRL_EN_BIT 0
`define CFT_CTRL_SEL_LSB 4
`define CFT_CTRL_SEL_MSB 6
`define CFT_THR_MSB 9
`define CFT_THR_MIN 10'h00a
`define CFT_THR_MAX 10'h3e8
`define CFT_THR_RST 10'h0c8
`define CFT_EN_RST 1'h1
`define CFT_SEL_RST 3'h1
`define CFT_SEL_MAX 3'h6
`define CFT_PCT_SCALE 32'h0000_0064
`define CFT_STAT_TRIP_BIT 0
`define CFT_STAT_FOC_BIT 1
`define CFT_STAT_COND_BIT 2
`define CFT_STAT_ZONE_LSB 3
`define CFT_STAT_ZONE_MSB 7
`endif

// ===== hdl/cft_pkg.sv
// Types shared by the closure-fault trip block
package cft_pkg;
   // Trigger source choices, in register encoding order
   typedef enum logic [2:0] {
      CFT_SEL_OFF,
      CFT_SEL_ZONE1,
      CFT_SEL_ZONE2,
      CFT_SEL_ZONE3,
      CFT_SEL_ZONE4,
      CFT_SEL_ZONE5,
      CFT_SEL_FAST_OC
   } cft_sel_e;
endpackage : cft_pkg

// ===== hdl/cft_trip.sv
// Closure-fault trip logic with APB register slave
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cft_defines.svh"

module cft_trip #(
   parameter int SAMPLE_W = 16,
   parameter int RATED_CURRENT = 1000
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`CFT_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic energise_condition_in,
   input wire logic zone1_started,
   input wire logic zone2_started,
   input wire logic zone3_started,
   input wire logic zone4_started,
   input wire logic zone5_started,
   input wire logic signed [SAMPLE_W-1:0] phase_l1_sample,
   input wire logic signed [SAMPLE_W-1:0] phase_l2_sample,
   input wire logic signed [SAMPLE_W-1:0] phase_l3_sample,
   output logic closure_fault_trip,
   output logic fast_overcurrent_started
);

   // Magnitude of a signed sample; the most negative code maps to its true size
   function automatic logic [SAMPLE_W-1:0] cft_mag(input logic signed [SAMPLE_W-1:0] s);
      logic [SAMPLE_W-1:0] m;
      m = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
      return m;
   endfunction : cft_mag

   // Percent comparison done in integers: |i|*100 > pct*rated, no division needed
   function automatic logic cft_above(input logic [SAMPLE_W-1:0] m,
                                      input logic [`CFT_THR_MSB:0] pct);
      logic [31:0] lhs;
      logic [31:0] rhs;
      lhs = 32'(m) * `CFT_PCT_SCALE;
      rhs = 32'(pct) * 32'(RATED_CURRENT);
      return lhs > rhs;
   endfunction : cft_above

   // Zone-started input belonging to a selection, low for non-zone choices
   function automatic logic cft_zone_pick(input logic [2:0] sel, input logic [4:0] zv);
      logic z;
      z = 1'b0;
      if (sel >= 3'(cft_pkg::CFT_SEL_ZONE1) && sel <= 3'(cft_pkg::CFT_SEL_ZONE5)) begin
         z = zv[3'(sel - 3'h1)];
      end
      return z;
   endfunction : cft_zone_pick

   logic ctrl_en_reg;
   logic ctrl_en_next;
   logic [2:0] ctrl_sel_reg;
   logic [2:0] ctrl_sel_next;
   logic [`CFT_THR_MSB:0] thr_reg;
   logic [`CFT_THR_MSB:0] thr_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic trip_reg;
   logic trip_next;
   logic [4:0] zone_vec;
   logic foc_now;
   logic source_active;
   logic addr_ok;
   logic wr_access;
   logic [31:0] rd_word;
   logic zone_hit;

   // All checks run on the sample clock and sleep through reset
   default clocking cft_cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Zone general starts already merge all phases upstream
   assign zone_vec = {zone5_started, zone4_started, zone3_started,
                      zone2_started, zone1_started};

   // Raw sample compare per phase, deliberately unfiltered for speed
   assign foc_now = cft_above(cft_mag(phase_l1_sample), thr_reg) |
                    cft_above(cft_mag(phase_l2_sample), thr_reg) |
                    cft_above(cft_mag(phase_l3_sample), thr_reg);

   // Selected zone start as a named net, so checks can look back at it
   assign zone_hit = cft_zone_pick(ctrl_sel_reg, zone_vec);

   // Exactly one source is looked at; Off and unused codes select nothing
   always_comb begin
      source_active = 1'b0;
      case (cft_pkg::cft_sel_e'(ctrl_sel_reg))
         cft_pkg::CFT_SEL_OFF: source_active = 1'b0;
         cft_pkg::CFT_SEL_FAST_OC: source_active = foc_now;
         default: source_active = zone_hit;
      endcase
   end

   // Trip follows its cause every sample clock, no timer in the path
   always_comb begin
      trip_next = ctrl_en_reg & energise_condition_in & source_active;
   end

   // APB decode; zero wait states so pready is constant high
   assign addr_ok = (paddr == `CFT_ADDR_CTRL) || (paddr == `CFT_ADDR_THR) ||
                    (paddr == `CFT_ADDR_STAT);
   assign wr_access = psel & penable & pwrite & addr_ok;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata = prdata_reg;

   // Read mux; status shows live state so software sees what trips
   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr)
         `CFT_ADDR_CTRL: begin
            rd_word[`CFT_CTRL_EN_BIT] = ctrl_en_reg;
            rd_word[`CFT_CTRL_SEL_MSB:`CFT_CTRL_SEL_LSB] = ctrl_sel_reg;
         end
         `CFT_ADDR_THR: begin
            rd_word[`CFT_THR_MSB:0] = thr_reg;
         end
         `CFT_ADDR_STAT: begin
            rd_word[`CFT_STAT_TRIP_BIT] = trip_reg;
            rd_word[`CFT_STAT_FOC_BIT] = foc_now;
            rd_word[`CFT_STAT_COND_BIT] = energise_condition_in;
            rd_word[`CFT_STAT_ZONE_MSB:`CFT_STAT_ZONE_LSB] = zone_vec;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Register writes; out-of-range values are refused so settings stay legal
   always_comb begin
      ctrl_en_next = ctrl_en_reg;
      ctrl_sel_next = ctrl_sel_reg;
      thr_next = thr_reg;
      prdata_next = prdata_reg;
      if (psel && !penable) begin
         prdata_next = rd_word;
      end
      if (wr_access && paddr == `CFT_ADDR_CTRL) begin
         ctrl_en_next = pwdata[`CFT_CTRL_EN_BIT];
         if (pwdata[`CFT_CTRL_SEL_MSB:`CFT_CTRL_SEL_LSB] <= `CFT_SEL_MAX) begin
            ctrl_sel_next = pwdata[`CFT_CTRL_SEL_MSB:`CFT_CTRL_SEL_LSB];
         end
      end
      if (wr_access && paddr == `CFT_ADDR_THR && pwdata[31:`CFT_THR_MSB+1] == '0 &&
          pwdata[`CFT_THR_MSB:0] >= `CFT_THR_MIN && pwdata[`CFT_THR_MSB:0] <= `CFT_THR_MAX) begin
         thr_next = pwdata[`CFT_THR_MSB:0];
      end
   end

   // State registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_en_reg <= `CFT_EN_RST;
         ctrl_sel_reg <= `CFT_SEL_RST;
         thr_reg <= `CFT_THR_RST;
         prdata_reg <= 32'h0000_0000;
         trip_reg <= 1'b0;
      end else begin
         ctrl_en_reg <= ctrl_en_next;
         ctrl_sel_reg <= ctrl_sel_next;
         thr_reg <= thr_next;
         prdata_reg <= prdata_next;
         trip_reg <= trip_next;
      end
   end

   // Detector status is combinational so a sample is seen in its own cycle
   assign fast_overcurrent_started = foc_now;
   assign closure_fault_trip = trip_reg;

   // Checks and coverage

   AST_TRIP_ON_CAUSE: assert property (ctrl_en_reg && energise_condition_in && source_active
      |=> closure_fault_trip) else $error("trip missing one cycle after cause");

   AST_OFF_QUIET: assert property (ctrl_sel_reg == 3'(cft_pkg::CFT_SEL_OFF)
      |=> !closure_fault_trip) else $error("trip while source is Off");

   AST_DISABLED_QUIET: assert property (!ctrl_en_reg |=> !closure_fault_trip)
      else $error("trip while function disabled");

   AST_SEL_LEGAL: assert property (ctrl_sel_reg <= `CFT_SEL_MAX)
      else $error("trigger select holds an illegal code");

   AST_ZONE_TRIP: assert property (ctrl_en_reg && energise_condition_in &&
      zone_hit |=> closure_fault_trip)
      else $error("selected zone start did not trip");

   AST_FOC_TRIP: assert property (ctrl_en_reg && energise_condition_in &&
      ctrl_sel_reg == 3'(cft_pkg::CFT_SEL_FAST_OC) && fast_overcurrent_started
      |=> closure_fault_trip) else $error("fast overcurrent did not trip");

   AST_THR_RANGE: assert property (thr_reg >= `CFT_THR_MIN && thr_reg <= `CFT_THR_MAX)
      else $error("threshold out of range");

   AST_ZONE_SOURCE: assert property (closure_fault_trip &&
      $past(ctrl_sel_reg) != 3'(cft_pkg::CFT_SEL_FAST_OC)
      |-> $past(zone_hit)) else $error("trip without zone start");

   AST_RELEASE: assert property ((!energise_condition_in || !source_active)
      |=> !closure_fault_trip) else $error("trip not released");

   COV_ZONE_TRIP: cover property (ctrl_sel_reg == 3'(cft_pkg::CFT_SEL_ZONE2) ##1 closure_fault_trip);
   COV_FOC_TRIP: cover property (ctrl_sel_reg == 3'(cft_pkg::CFT_SEL_FAST_OC) ##1 closure_fault_trip);
   COV_TRIP_DROP: cover property (closure_fault_trip ##1 !closure_fault_trip);
   COV_BAD_ADDR: cover property (pslverr);

endmodule : cft_trip
`default_nettype wire

// ===== testbench/cft_far_model.sv
// Far-side user logic and zone start model
`timescale 1ns/100ps
`default_nettype none
module cft_far_model (
   input wire logic clk,
   input wire logic cond_cmd,
   input wire logic [14:0] phase_cmd,
   output logic energise_condition_in,
   output logic [4:0] zone_started
);
   // Registered, so changes land just after an edge like real logic outputs
   always_ff @(posedge clk) begin
      energise_condition_in <= cond_cmd;
      for (int k = 0; k < 5; k++) begin
         zone_started[k] <= |phase_cmd[3*k +: 3];
      end
   end
endmodule : cft_far_model
`default_nettype wire

// ===== testbench/cft_trip_bench.sv
// Self-checking bench of the closure-fault trip block
`timescale 1ns/100ps
`default_nettype none
`include "cft_defines.svh"
module cft_trip_bench;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, cmd, cond, trip, foc, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [14:0] pc;
   logic [4:0] zs;
   logic signed [15:0] s1, s2, s3;
   int err_total = 0;
   int comparisons = 0;
   int thr_tab [6] = '{200, 200, 200, 10, 10, 1000};
   int smp_tab [6] = '{2000, 2001, -2001, 101, 100, 10001};
   // Clock, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   cft_far_model far_u (.clk(clk), .cond_cmd(cmd), .phase_cmd(pc), .energise_condition_in(cond),
      .zone_started(zs));
   cft_trip dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .energise_condition_in(cond), .zone1_started(zs[0]), .zone2_started(zs[1]),
      .zone3_started(zs[2]), .zone4_started(zs[3]), .zone5_started(zs[4]), .phase_l1_sample(s1),
      .phase_l2_sample(s2), .phase_l3_sample(s3), .closure_fault_trip(trip),
      .fast_overcurrent_started(foc));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No wait-state count assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rd, x);
   endtask : rdchk
   // One sample on phase ph; others held at zero
   task automatic drive(input logic c, input logic [14:0] p, input int smp, input int ph);
      @(posedge clk);
      cmd <= c;
      pc <= p;
      s1 <= (ph == 0) ? 16'(smp) : 16'h0;
      s2 <= (ph == 1) ? 16'(smp) : 16'h0;
      s3 <= (ph == 2) ? 16'(smp) : 16'h0;
   endtask : drive
   // Far model adds one edge, trip register one more
   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic stop_test;
      $display("err_total %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      stop_test();
   end
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata, cmd, pc, s1, s2, s3} = '0;
      sys_rst = 1'b1;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk(`CFT_ADDR_CTRL, 32'h0000_0011);
      rdchk(`CFT_ADDR_THR, 32'h0000_00c8);
      apb(1'b0, 12'h00c, 32'h0);
      chk({31'h0, e}, 32'h1);
      // Each zone in turn: the other zones must not trip, its own start must
      for (int z = 0; z < 5; z++) begin
         apb(1'b1, `CFT_ADDR_CTRL, (32'(z + 1) << 4) | 32'h1);
         drive(1'b1, ~(15'h7 << (3 * z)), 0, 0);
         settle();
         chk({31'h0, trip}, 32'h0);
         drive(1'b1, 15'h1 << (3 * z + (z % 3)), 0, 0);
         settle();
         chk({31'h0, trip}, 32'h1);
         drive(1'b0, 15'h1 << (3 * z), 0, 0);
         settle();
         chk({31'h0, trip}, 32'h0);
      end
      // Disabled, then select Off
      apb(1'b1, `CFT_ADDR_CTRL, 32'h10);
      drive(1'b1, 15'h7fff, 0, 0);
      settle();
      chk({31'h0, trip}, 32'h0);
      apb(1'b1, `CFT_ADDR_CTRL, 32'h01);
      settle();
      chk({31'h0, trip}, 32'h0);
      // Out-of-range threshold is ignored
      apb(1'b1, `CFT_ADDR_THR, 32'h9);
      rdchk(`CFT_ADDR_THR, 32'h0000_00c8);
      apb(1'b1, `CFT_ADDR_CTRL, 32'h61);
      // Single samples around each threshold, on rotating phases
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `CFT_ADDR_THR, 32'(thr_tab[i]));
         drive(1'b1, 15'h0, smp_tab[i], i % 3);
         settle();
         rd = 32'((smp_tab[i] < 0 ? -smp_tab[i] : smp_tab[i]) * 100 > thr_tab[i] * 1000);
         chk({31'h0, foc}, rd);
         chk({31'h0, trip}, rd);
      end
      // Status shows trip, detector, condition and zones 1 and 3 in their own bits
      drive(1'b1, 15'h0041, 10001, 2);
      settle();
      rdchk(`CFT_ADDR_STAT, 32'h0000_002f);
      // Select code 7 is refused but enable is written; status takes no writes and no error
      apb(1'b1, `CFT_ADDR_CTRL, 32'h71);
      apb(1'b1, `CFT_ADDR_STAT, 32'h0);
      chk({31'h0, e}, 32'h0);
      rdchk(`CFT_ADDR_CTRL, 32'h0000_0061);
      // Source drops while the condition still holds: trip must release
      drive(1'b1, 15'h0041, 0, 0);
      settle();
      chk({31'h0, foc}, 32'h0);
      chk({31'h0, trip}, 32'h0);
      stop_test();
   end
endmodule : cft_trip_bench
`default_nettype wire
